//--- rtl/brk_fail_pkg.sv
package brk_fail_pkg;

    localparam int CLK_HZ = 250000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 18;
    localparam int MS_W = 16;

    localparam logic [MS_W-1:0] BACKUP_MIN_MS = 16'h0064;
    localparam logic [MS_W-1:0] BACKUP_MAX_MS = 16'hEA60;
    localparam logic [MS_W-1:0] BACKUP_DEF_MS = 16'h03E8;
    localparam logic [MS_W-1:0] RETRIP_MAX_MS = 16'h03E8;
    localparam logic [MS_W-1:0] RETRIP_DEF_MS = 16'h0064;
    localparam logic [MS_W-1:0] PULSE_MAX_MS = 16'hEA60;
    localparam logic [MS_W-1:0] PULSE_DEF_MS = 16'h0064;
    localparam int PHASES = 3;

    // Wishbone register map.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_BACKUP = 4'h1;
    localparam logic [3:0] REG_RETRIP = 4'h2;
    localparam logic [3:0] REG_PULSE = 4'h3;
    localparam logic [3:0] REG_STATE = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT = 4'h5;
    localparam logic [3:0] REG_IRQ_MASK = 4'h6;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RETRIP_BIT = 2;
    localparam int CTRL_SP_BIT = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [1:0]
    {
        MODE_OFF,
        MODE_CURRENT,
        MODE_CONTACT,
        MODE_BOTH
    } op_mode_e;

    typedef struct packed
    {
        logic common_start_request;
        logic [PHASES-1:0] phase_start_request;
        logic breaker_closed_common;
        logic [PHASES-1:0] breaker_closed_phase;
        logic [PHASES-1:0] phase_current_threshold;
        logic residual_current_threshold;
        logic inhibit_input;
    } fail_in_s;

    typedef struct packed
    {
        logic backup_trip_out;
        logic [PHASES-1:0] retrip_out;
    } fail_out_s;

    function automatic logic [MS_W-1:0] clamp_ms(input logic [MS_W-1:0] v,
        input logic [MS_W-1:0] lo, input logic [MS_W-1:0] hi);
        clamp_ms = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp_ms

endpackage : brk_fail_pkg

//--- rtl/ms_tick.sv
`timescale 1ns/1ns
`default_nettype none
module ms_tick
    import brk_fail_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick.
    output logic tick_o
);
    logic [TICK_W-1:0] cnt;
    logic [TICK_W-1:0] next_cnt;
    logic next_tick;

    always_comb
    begin
        next_tick = (cnt == TICK_W'(TICK_CYCLES - 1));
        next_cnt = next_tick ? '0 : cnt + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule : ms_tick
`default_nettype wire

//--- rtl/phase_timer.sv
`timescale 1ns/1ns
`default_nettype none
module phase_timer
    import brk_fail_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Control.
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic launch_i,
    input wire logic clear_i,
    input wire logic [MS_W-1:0] limit_i,
    // Status.
    output logic running_o,
    output logic expired_o
);
    logic [MS_W-1:0] cnt;
    logic [MS_W-1:0] next_cnt;
    logic next_running;
    logic next_expired;

    always_comb
    begin
        next_cnt = cnt;
        next_running = running_o;
        next_expired = expired_o;
        if (clear_i || !start_i)
        begin
            next_cnt = '0;
            next_running = 1'b0;
            next_expired = 1'b0;
        end
        else if (launch_i)
        begin
            next_cnt = '0;
            next_running = 1'b1;
            next_expired = (limit_i == '0);
        end
        else if (running_o && !expired_o && tick_i)
        begin
            next_cnt = cnt + 1'b1;
            next_expired = (cnt + 1'b1 >= limit_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            running_o <= 1'b0;
            expired_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            running_o <= next_running;
            expired_o <= next_expired;
        end
    end
endmodule : phase_timer
`default_nettype wire

//--- rtl/brk_fail.sv
`timescale 1ns/1ns
`default_nettype none
module brk_fail
    import brk_fail_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Protection inputs.
    input wire fail_in_s pins_i,
    // Trip commands and interrupt.
    output fail_out_s trip_o,
    output logic irq_o
);
    fail_in_s meta;
    fail_in_s sync;
    fail_in_s prev;

    logic [1:0] mode_bits;
    logic retrip_en;
    logic single_pole;
    logic [MS_W-1:0] backup_ms;
    logic [MS_W-1:0] retrip_ms;
    logic [MS_W-1:0] pulse_ms;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0] next_mode_bits;
    logic next_retrip_en;
    logic next_single_pole;
    logic [MS_W-1:0] next_backup_ms;
    logic [MS_W-1:0] next_retrip_ms;
    logic [MS_W-1:0] next_pulse_ms;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [31:0] next_dat;
    logic next_ack;

    op_mode_e mode;
    logic tick;
    logic wr;
    logic [3:0] widx;
    logic off;
    logic [PHASES-1:0] start;
    logic [PHASES-1:0] launch;
    logic [PHASES-1:0] cur_fault;
    logic [PHASES-1:0] cont_fault;
    logic [PHASES-1:0] fault;
    logic [PHASES-1:0] clear;
    logic [PHASES-1:0] bk_run;
    logic [PHASES-1:0] bk_exp;
    logic [PHASES-1:0] rt_run;
    logic [PHASES-1:0] rt_exp;
    logic [PHASES:0] cmd_set;
    logic [PHASES:0] cmd;
    logic [PHASES:0] next_cmd;
    logic [MS_W-1:0] hold [PHASES+1];
    logic [MS_W-1:0] next_hold [PHASES+1];
    fail_out_s next_trip;

    // Inputs come from outside the clock domain.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= pins_i;
            sync <= meta;
            prev <= sync;
        end
    end

    ms_tick u_tick
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // Supervision and timer launch per phase.
    always_comb
    begin
        mode = op_mode_e'(mode_bits);
        off = (mode == MODE_OFF) || sync.inhibit_input;
        for (int p = 0; p < PHASES; p++)
        begin
            if (single_pole)
            begin
                start[p] = sync.phase_start_request[p] | sync.common_start_request;
                launch[p] = (sync.phase_start_request[p] && !prev.phase_start_request[p])
                    || (sync.common_start_request && !prev.common_start_request);
                cur_fault[p] = sync.phase_current_threshold[p]
                    | sync.residual_current_threshold;
                cont_fault[p] = sync.breaker_closed_phase[p];
            end
            else
            begin
                start[p] = (p == 0) && sync.common_start_request;
                launch[p] = (p == 0) && sync.common_start_request
                    && !prev.common_start_request;
                cur_fault[p] = (|sync.phase_current_threshold)
                    | sync.residual_current_threshold;
                cont_fault[p] = sync.breaker_closed_common;
            end
            unique case (mode)
                MODE_CURRENT: fault[p] = cur_fault[p];
                MODE_CONTACT: fault[p] = cont_fault[p];
                MODE_BOTH: fault[p] = cur_fault[p] | cont_fault[p];
                MODE_OFF: fault[p] = 1'b0;
            endcase
            clear[p] = off || !fault[p];
        end
    end

    for (genvar g = 0; g < PHASES; g++)
    begin : g_ph
        phase_timer u_bk
        (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .start_i(start[g]),
            .launch_i(launch[g]),
            .clear_i(clear[g]),
            .limit_i(backup_ms),
            .running_o(bk_run[g]),
            .expired_o(bk_exp[g])
        );
        phase_timer u_rt
        (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .start_i(start[g]),
            .launch_i(launch[g]),
            .clear_i(clear[g]),
            .limit_i(retrip_ms),
            .running_o(rt_run[g]),
            .expired_o(rt_exp[g])
        );
    end

    // Trip commands with minimum pulse stretch.
    always_comb
    begin
        cmd_set[PHASES] = |(bk_exp & fault) && !off;
        for (int p = 0; p < PHASES; p++)
            cmd_set[p] = single_pole && retrip_en && rt_exp[p] && bk_run[p]
                && fault[p] && !off;
        for (int c = 0; c <= PHASES; c++)
        begin
            next_hold[c] = hold[c];
            next_cmd[c] = cmd[c];
            if (off)
            begin
                next_cmd[c] = 1'b0;
                next_hold[c] = '0;
            end
            else if (cmd_set[c])
            begin
                next_cmd[c] = 1'b1;
                next_hold[c] = pulse_ms;
            end
            else if (cmd[c])
            begin
                if (hold[c] == '0)
                    next_cmd[c] = 1'b0;
                else if (tick)
                    next_hold[c] = hold[c] - 1'b1;
            end
        end
        next_trip.backup_trip_out = next_cmd[PHASES];
        next_trip.retrip_out = next_cmd[PHASES-1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd <= '0;
            trip_o <= '0;
            for (int c = 0; c <= PHASES; c++)
                hold[c] <= '0;
        end
        else
        begin
            cmd <= next_cmd;
            trip_o <= next_trip;
            for (int c = 0; c <= PHASES; c++)
                hold[c] <= next_hold[c];
        end
    end

    // Register file.
    always_comb
    begin
        wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
        widx = adr_i[5:2];
        next_mode_bits = mode_bits;
        next_retrip_en = retrip_en;
        next_single_pole = single_pole;
        next_backup_ms = backup_ms;
        next_retrip_ms = retrip_ms;
        next_pulse_ms = pulse_ms;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_ack = cyc_i && stb_i && !ack_o;
        next_dat = '0;
        if (wr)
        begin
            unique case (widx)
                REG_CTRL:
                begin
                    next_mode_bits = dat_i[CTRL_MODE_LSB+:2];
                    next_retrip_en = dat_i[CTRL_RETRIP_BIT];
                    next_single_pole = dat_i[CTRL_SP_BIT];
                end
                REG_BACKUP: next_backup_ms = clamp_ms(dat_i[MS_W-1:0], BACKUP_MIN_MS,
                    BACKUP_MAX_MS);
                REG_RETRIP: next_retrip_ms = clamp_ms(dat_i[MS_W-1:0], '0,
                    RETRIP_MAX_MS);
                REG_PULSE: next_pulse_ms = clamp_ms(dat_i[MS_W-1:0], '0,
                    PULSE_MAX_MS);
                REG_IRQ_STAT: next_irq_stat = irq_stat & ~dat_i[IRQ_W-1:0];
                REG_IRQ_MASK: next_irq_mask = dat_i[IRQ_W-1:0];
                default: next_irq_mask = irq_mask;
            endcase
        end
        // New trip events set after the clear so a set wins.
        next_irq_stat = next_irq_stat | (next_cmd & ~cmd);
        if (cyc_i && stb_i && !we_i)
        begin
            unique case (widx)
                REG_CTRL: next_dat = {28'h0, single_pole, retrip_en, mode_bits};
                REG_BACKUP: next_dat = {16'h0, backup_ms};
                REG_RETRIP: next_dat = {16'h0, retrip_ms};
                REG_PULSE: next_dat = {16'h0, pulse_ms};
                REG_STATE: next_dat = {15'h0, off, rt_exp, bk_exp, rt_run, bk_run,
                    cmd};
                REG_IRQ_STAT: next_dat = {28'h0, irq_stat};
                REG_IRQ_MASK: next_dat = {28'h0, irq_mask};
                default: next_dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_bits <= 2'h0;
            retrip_en <= 1'b0;
            single_pole <= 1'b0;
            backup_ms <= BACKUP_DEF_MS;
            retrip_ms <= RETRIP_DEF_MS;
            pulse_ms <= PULSE_DEF_MS;
            irq_stat <= '0;
            irq_mask <= '0;
            ack_o <= 1'b0;
            dat_o <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            mode_bits <= next_mode_bits;
            retrip_en <= next_retrip_en;
            single_pole <= next_single_pole;
            backup_ms <= next_backup_ms;
            retrip_ms <= next_retrip_ms;
            pulse_ms <= next_pulse_ms;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            ack_o <= next_ack;
            dat_o <= next_dat;
            irq_o <= |(next_irq_stat & next_irq_mask);
        end
    end
endmodule : brk_fail
`default_nettype wire

//--- testbench/brk_fail_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module brk_fail_assertions
    import brk_fail_pkg::*;
(
    // Watched ports.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire fail_in_s pins_i,
    input wire fail_out_s trip_o,
    input wire logic irq_o
);
    logic [3:0] ctrl;
    logic [3:0] next_ctrl;
    wire logic [2:0] rt = trip_o.retrip_out;
    wire logic off = ctrl[1:0] == MODE_OFF;
    wire logic cur = ctrl[1:0] == MODE_CURRENT;
    wire logic cnt = ctrl[1:0] == MODE_CONTACT;
    wire logic go = cyc_i && stb_i && we_i && ack_o && sel_i[0];

    // Shadow of the control register, updated at each acknowledged write.
    always_comb
    begin
        next_ctrl = ctrl;
        if (go && adr_i[5:2] == REG_CTRL)
        begin
            next_ctrl = dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        ctrl <= rst_i ? 4'h0 : next_ctrl;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_off;
        off [*5] |-> trip_o == '0;
    endproperty
    a_off: assert property (p_off) else $error("trip while mode off");
    property p_inhibit;
        pins_i.inhibit_input [*6] |-> trip_o == '0;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("trip while inhibited");
    property p_common;
        !ctrl[CTRL_SP_BIT] [*8] |-> rt == '0;
    endproperty
    a_common: assert property (p_common) else $error("retrip in common variant");
    property p_rt_off;
        !ctrl[CTRL_RETRIP_BIT] [*8] |-> rt == '0;
    endproperty
    a_rt_off: assert property (p_rt_off) else $error("retrip while disabled");
    property p_rt_start;
        $rose(rt[0]) |-> $past(pins_i.phase_start_request[0] | pins_i.common_start_request, 2);
    endproperty
    a_rt_start: assert property (p_rt_start) else $error("retrip without start");
    property p_rt_cur;
        $rose(rt[0]) && cur |->
            $past(pins_i.phase_current_threshold[0] | pins_i.residual_current_threshold, 2);
    endproperty
    a_rt_cur: assert property (p_rt_cur) else $error("retrip without current");
    property p_rt_cb;
        $rose(rt[0]) && cnt |-> $past(pins_i.breaker_closed_phase[0], 2);
    endproperty
    a_rt_cb: assert property (p_rt_cb) else $error("retrip with breaker open");
    property p_bk_start;
        $rose(trip_o.backup_trip_out) |->
            $past(pins_i.common_start_request | (|pins_i.phase_start_request), 2);
    endproperty
    a_bk_start: assert property (p_bk_start) else $error("backup without start");
    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not a one cycle pulse");
    property p_reset;
        disable iff (1'b0) rst_i |=> trip_o == '0 && !irq_o && !ack_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active after reset");

    c_retrip: cover property ($rose(rt[0]));
    c_irq: cover property ($rose(irq_o));
    c_inhibit: cover property (pins_i.inhibit_input && pins_i.common_start_request);
endmodule : brk_fail_assertions

bind brk_fail brk_fail_assertions brk_fail_assertions_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .sel_i(sel_i),
    .adr_i(adr_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .pins_i(pins_i),
    .trip_o(trip_o),
    .irq_o(irq_o)
);
`default_nettype wire

//--- testbench/upstream_model.sv
`timescale 1ns/1ns
`default_nettype none
module upstream_model
    import brk_fail_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Requested state and launch.
    input wire fail_in_s want_i,
    input wire logic launch_i,
    // Protection inputs.
    output fail_in_s pins_o
);
    fail_in_s next_pins;

    // Starts stay low until launch, so each launch is one clean rising edge.
    always_comb
    begin
        next_pins = want_i;
        next_pins.common_start_request = want_i.common_start_request & launch_i;
        next_pins.phase_start_request = want_i.phase_start_request & {PHASES{launch_i}};
    end

    initial pins_o = '0;

    always @(posedge clk_i)
    begin
        pins_o <= next_pins;
    end
endmodule : upstream_model
`default_nettype wire

//--- testbench/tb_brk_fail.sv
`timescale 1ns/1ns
`default_nettype none
module tb_brk_fail
    import brk_fail_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic launch = 1'b0;
    fail_in_s want = '0;
    fail_in_s pins;
    fail_in_s w;
    fail_out_s trip;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [3:0] ctrl;
    logic [3:0] mask;
    logic [2:0] ert;
    logic [2:0] erun;
    logic [3:0] ridx [5] = '{REG_CTRL, REG_BACKUP, REG_RETRIP, REG_PULSE, 4'h7};
    logic [31:0] rdef [5] = '{32'h0, 32'h3E8, 32'h64, 32'h64, 32'h0};
    logic [3:0] cidx [5] = '{REG_BACKUP, REG_BACKUP, REG_RETRIP, REG_PULSE, 4'h7};
    logic [31:0] cwr [5] = '{32'h63, 32'hEA61, 32'h3E9, 32'hEA61, 32'h5};
    logic [31:0] cexp [5] = '{32'h64, 32'hEA60, 32'h3E8, 32'hEA60, 32'h0};

    always #2 clk = ~clk;

    upstream_model upstream_model_inst (.clk_i(clk), .want_i(want), .launch_i(launch),
        .pins_o(pins));

    brk_fail brk_fail_inst (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(4'hF), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .pins_i(pins), .trip_o(trip), .irq_o(irq));

    task automatic wb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= {idx, 2'b00};
        wdat <= wd;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic chk_reg(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", what, e, g);
            err_count++;
        end
    endtask : chk_reg

    task automatic chk_pin(input string what, input logic [3:0] e, input logic [3:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", what, e, g);
            err_count++;
        end
    endtask : chk_pin

    // Reference model: which timers run and which phases retrip.
    function automatic void predict(input logic [3:0] c, input fail_in_s p);
        logic sp;
        logic [2:0] st;
        logic [2:0] fc;
        logic [2:0] fk;
        logic [2:0] f;
        sp = c[CTRL_SP_BIT];
        st = sp ? p.phase_start_request | {3{p.common_start_request}}
                : {2'b00, p.common_start_request};
        fc = sp ? p.phase_current_threshold | {3{p.residual_current_threshold}}
                : {2'b00, |{p.phase_current_threshold, p.residual_current_threshold}};
        fk = sp ? p.breaker_closed_phase : {2'b00, p.breaker_closed_common};
        case (c[1:0])
            MODE_CURRENT: f = fc;
            MODE_CONTACT: f = fk;
            MODE_BOTH: f = fc | fk;
            default: f = 3'b000;
        endcase
        erun = p.inhibit_input ? 3'b000 : st & f;
        ert = (sp && c[CTRL_RETRIP_BIT]) ? erun : 3'b000;
    endfunction : predict

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            test_done();
        end
    end

    initial
    begin
        void'($urandom(32'hDE37423D));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, ridx[i], 32'h0);
            chk_reg("reset value", rdef[i], rd);
        end
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b1, cidx[i], cwr[i]);
            wb(1'b0, cidx[i], 32'h0);
            chk_reg("clamped value", cexp[i], rd);
        end
        wb(1'b1, REG_RETRIP, 32'h0);
        wb(1'b1, REG_PULSE, 32'h0);
        for (int i = 0; i < 40; i++)
        begin
            ctrl = 4'($urandom);
            mask = {1'b0, {3{i[0]}}};
            w = fail_in_s'($urandom);
            w.inhibit_input = ($urandom_range(3) == 0);
            wb(1'b1, REG_CTRL, {28'h0, ctrl});
            wb(1'b1, REG_IRQ_MASK, {28'h0, mask});
            want <= w;
            repeat (8) @(posedge clk);
            launch <= 1'b1;
            repeat (30) @(posedge clk);
            predict(ctrl, w);
            chk_pin("trip", {1'b0, ert}, trip);
            chk_pin("irq", {3'b000, |(ert & mask[2:0])}, {3'b000, irq});
            wb(1'b0, REG_STATE, 32'h0);
            chk_reg("backup running", {29'h0, erun}, {29'h0, rd[6:4]});
            launch <= 1'b0;
            repeat (30) @(posedge clk);
            chk_pin("trip after start fall", 4'h0, trip);
            wb(1'b0, REG_IRQ_STAT, 32'h0);
            chk_reg("irq status", {29'h0, ert}, rd);
            wb(1'b1, REG_IRQ_STAT, 32'hF);
            wb(1'b0, REG_IRQ_STAT, 32'h0);
            chk_reg("irq status cleared", 32'h0, rd);
        end
        test_done();
    end
endmodule : tb_brk_fail
`default_nettype wire
